// file: rtl/pssc_top.sv
// Purpose: strap capture, aux control pin muxing and link status outputs
// Assumes: core_clk 100 MHz; pins asynchronous; link status from core logic
// Notes:   two-way pins are split into in, out and output enable
`include "pssc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module pssc_top
   import pssc_pkg::*;
#(
   parameter int DW = 29
) (
   input  wire logic              core_clk,
   input  wire logic              rst_n,
   input  wire logic              power_down_n,
   input  wire logic              output_enable_n,
   input  wire logic [1:0]        bus_width_select,
   input  wire logic              control_protocol_select,
   input  wire logic              address_strap_mid_in,
   input  wire logic              address_strap_low_in,
   input  wire logic              aux_ctl_three_src,
   input  wire logic              aux_ctl_zero_src,
   input  wire logic              pixel_clock_src,
   input  wire logic [DW-1:0]     pixel_data_src,
   input  wire logic              link_error,
   input  wire logic              pll_locked,
   input  wire logic              word_aligned,
   input  wire logic              audio_clock_source_sel,
   input  wire logic              audio_ws_src,
   input  wire logic              audio_sck_src,
   output var  logic              aux_control_out_three,
   output var  logic              aux_control_out_three_oe,
   output var  logic              aux_control_out_zero,
   output var  logic              aux_control_out_zero_oe,
   output var  logic              pixel_clock_out,
   output var  logic [DW-1:0]     pixel_data_out,
   output var  logic              pixel_out_oe,
   output var  logic [1:0]        address_strap_q,
   output var  logic              strap_valid,
   output var  logic              ctl_proto_i2c,
   output var  logic              powered_down,
   output var  logic              error_out_n,
   output var  logic              lock_out,
   output var  logic              audio_ws_out,
   output var  logic              audio_ws_oe,
   output var  logic              audio_sck_out,
   output var  logic              audio_sck_oe
);
   import pssc_pkg::*;
   // ==========================================================
   // pin synchronisers
   // ==========================================================
   logic [6:0] raw;
   logic [6:0] sy;
   // every pin reads low until synchronised, so reset never fakes a wake
   pssc_sync #(.W(7), .INIT(64'h0)) u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .din      (raw),
      .dout     (sy)
   );
   assign raw = {bus_width_select, control_protocol_select,
                 address_strap_mid_in, address_strap_low_in,
                 output_enable_n, power_down_n};
   logic pwr_on;
   logic oe_n_s;
   logic [1:0] bws_s;
   assign pwr_on = sy[0];
   assign oe_n_s = sy[1];
   assign bws_s  = sy[6:5];
   // ==========================================================
   // state
   // ==========================================================
   typedef struct packed {
      pssc_state_t             st;
      logic [`PSSC_CNT_W-1:0]  cnt;
      logic                    first;
      logic [1:0]              addr;
      logic                    proto;
      logic                    valid;
      logic                    a3;
      logic                    a3_oe;
      logic                    a0;
      logic                    a0_oe;
      logic                    pclk;
      logic [DW-1:0]           pdat;
      logic                    poe;
      logic                    err_n;
      logic                    lock;
      logic                    ws;
      logic                    ws_oe;
      logic                    sck;
      logic                    sck_oe;
      logic                    pd;
   } pssc_st_t;
   pssc_st_t s_q;
   pssc_st_t s_d;
   logic hbw;
   logic drv;
   always_comb begin
      s_d = s_q;
      hbw = (bws_s == `PSSC_BWS_OPEN);
      drv = (s_q.st == PSSC_ST_RUN) && !oe_n_s;
      unique case (s_q.st)
         PSSC_ST_DOWN: begin
            s_d.valid = 1'b0;
            if (pwr_on) begin
               s_d.st  = PSSC_ST_SETTLE;
               s_d.cnt = '0;
            end
         end
         PSSC_ST_SETTLE: begin
            s_d.cnt = s_q.cnt + `PSSC_CNT_W'(1);
            if (!pwr_on) begin
               s_d.st = PSSC_ST_DOWN;
            end else if (s_q.cnt == `PSSC_CNT_W'(`PSSC_SETTLE_CYC - 1)) begin
               s_d.st    = PSSC_ST_RUN;
               s_d.addr  = sy[3:2];
               s_d.valid = 1'b1;
               if (s_q.first) begin
                  s_d.proto = sy[4];
                  s_d.first = 1'b0;
               end
            end
         end
         PSSC_ST_RUN: begin
            if (!pwr_on) begin
               s_d.st = PSSC_ST_DOWN;
            end
         end
         default: s_d.st = PSSC_ST_DOWN;
      endcase
      // aux controls: plain pass-through, never encrypted, zero outside hbw
      s_d.a3    = hbw & aux_ctl_three_src;
      s_d.a0    = hbw & aux_ctl_zero_src;
      s_d.a3_oe = drv;
      s_d.a0_oe = drv;
      s_d.poe   = drv;
      s_d.pclk  = pixel_clock_src;
      s_d.pdat  = pixel_data_src;
      s_d.err_n = !(pwr_on && link_error);
      s_d.lock  = !pwr_on || (pll_locked && word_aligned);
      s_d.ws_oe  = !audio_clock_source_sel;
      s_d.sck_oe = !audio_clock_source_sel;
      s_d.ws     = audio_ws_src;
      s_d.sck    = audio_sck_src;
      s_d.pd     = (s_d.st == PSSC_ST_DOWN);
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         s_q        <= '0;
         s_q.st     <= PSSC_ST_DOWN;
         s_q.first  <= 1'b1;
         s_q.proto  <= `PSSC_PROTO_UART;
         s_q.err_n  <= 1'b1;
         s_q.lock   <= 1'b1;
         s_q.ws_oe  <= 1'b1;
         s_q.sck_oe <= 1'b1;
         s_q.pd     <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end
   // ==========================================================
   // outputs
   // ==========================================================
   assign aux_control_out_three    = s_q.a3;
   assign aux_control_out_three_oe = s_q.a3_oe;
   assign aux_control_out_zero     = s_q.a0;
   assign aux_control_out_zero_oe  = s_q.a0_oe;
   assign pixel_clock_out          = s_q.pclk;
   assign pixel_data_out           = s_q.pdat;
   assign pixel_out_oe             = s_q.poe;
   assign address_strap_q          = s_q.addr;
   assign strap_valid              = s_q.valid;
   assign ctl_proto_i2c            = s_q.proto;
   assign powered_down             = s_q.pd;
   assign error_out_n              = s_q.err_n;
   assign lock_out                 = s_q.lock;
   assign audio_ws_out             = s_q.ws;
   assign audio_ws_oe              = s_q.ws_oe;
   assign audio_sck_out            = s_q.sck;
   assign audio_sck_oe             = s_q.sck_oe;
   // ==========================================================
   // checks
   // ==========================================================
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   chk_aux_oe_strap: assert property (
         aux_control_out_zero_oe |-> strap_valid)
      else $error("aux driver on before strap latched");
   chk_aux_three_oe: assert property (
         aux_control_out_three_oe |-> strap_valid)
      else $error("aux three driver on before strap latched");
   chk_aux_zero_hbw: assert property (
         !hbw |=> !aux_control_out_zero)
      else $error("aux zero carries data outside hbw");
   chk_aux_pass: assert property (
         hbw |=> aux_control_out_three == $past(aux_ctl_three_src))
      else $error("aux three not passed through");
   chk_proto_fixed: assert property (
         !s_q.first && !$past(s_q.first) |-> $stable(ctl_proto_i2c))
      else $error("protocol role changed after power-up");
   chk_err_pd: assert property (
         !pwr_on |=> error_out_n)
      else $error("error output active in power-down");
   chk_lock_pd: assert property (
         !pwr_on |=> lock_out)
      else $error("lock low in power-down");
   chk_lock_val: assert property (
         pwr_on && !(pll_locked && word_aligned) |=> !lock_out)
      else $error("lock high without pll lock and alignment");
   chk_ws_dir: assert property (
         audio_clock_source_sel |=> !audio_ws_oe && !audio_sck_oe)
      else $error("audio pins still driven in external mode");
   chk_pd_enter: assert property (
         s_q.st == PSSC_ST_RUN && !pwr_on |=> powered_down)
      else $error("power-down not entered");
   chk_oe_float: assert property (
         oe_n_s |=> !pixel_out_oe)
      else $error("outputs driven while disabled");
   cov_wake: cover property (powered_down ##1 !powered_down ##[1:20] strap_valid);
   cov_hbw: cover property (hbw && aux_control_out_zero);
   cov_i2c: cover property (ctl_proto_i2c && strap_valid);
   cov_uart: cover property (!ctl_proto_i2c && strap_valid);
   cov_ext_audio: cover property (!audio_ws_oe && !audio_sck_oe);
endmodule
`default_nettype wire

// file: rtl/pssc_cfg.svh
// Purpose: constants for the pin strap and status control block
// Assumes: core_clk at 100 MHz
// Notes:   settle time, counter width, strap codes and the protocol reset value live here
`ifndef PSSC_CFG_SVH
`define PSSC_CFG_SVH
`define PSSC_CLK_MHZ      100
`define PSSC_SETTLE_NS    40
`define PSSC_SETTLE_CYC   ((`PSSC_SETTLE_NS * `PSSC_CLK_MHZ + 999) / 1000)
`define PSSC_CNT_W        4
`define PSSC_BWS_LOW      2'h0
`define PSSC_BWS_HIGH     2'h1
`define PSSC_BWS_OPEN     2'h2
`define PSSC_PROTO_UART   1'h0
`define PSSC_PROTO_I2C    1'h1
`endif

// file: rtl/pssc_pkg.sv
// Purpose: shared types of the pin strap and status control block
// Assumes: nothing
// Notes:   constants are in pssc_cfg.svh
package pssc_pkg;
   typedef enum logic [1:0] {
      PSSC_ST_DOWN   = 2'b00,
      PSSC_ST_SETTLE = 2'b01,
      PSSC_ST_RUN    = 2'b10
   } pssc_state_t;
   typedef enum logic [1:0] {
      PSSC_W24  = 2'b00,
      PSSC_W32  = 2'b01,
      PSSC_WHBW = 2'b10
   } pssc_width_t;
endpackage

// file: rtl/pssc_sync.sv
// Purpose: three-flop synchroniser with agreement filter
// Assumes: input is asynchronous to core_clk
// Notes:   output changes once stages two and three agree
`timescale 1ns/1ns
`default_nettype none
module pssc_sync #(
   parameter int          W    = 1,
   parameter logic [63:0] INIT = 64'h0
) (
   input  wire logic         core_clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] din,
   output var  logic [W-1:0] dout
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
      logic [W-1:0] s3;
      logic [W-1:0] o;
   } pssc_sync_st_t;
   pssc_sync_st_t st_q;
   pssc_sync_st_t st_d;
   always_comb begin
      st_d    = st_q;
      st_d.s1 = din;
      st_d.s2 = st_q.s1;
      st_d.s3 = st_q.s2;
      for (int i = 0; i < W; i++) begin
         if (st_q.s2[i] == st_q.s3[i]) begin
            st_d.o[i] = st_q.s3[i];
         end
      end
   end
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= {4{INIT[W-1:0]}};
      end else begin
         st_q <= st_d;
      end
   end
   assign dout = st_q.o;
endmodule
`default_nettype wire

// file: bench/pssc_board_model.sv
// Purpose: board side of the two strap pins
// Assumes: strap resistor levels are chosen by the bench
// Notes:   pin level resolves driver enable against the resistor
`timescale 1ns/1ns
`default_nettype none
module pssc_board_model (
   input  wire logic strap_mid_hi,
   input  wire logic strap_low_hi,
   input  wire logic mid_out,
   input  wire logic mid_oe,
   input  wire logic low_out,
   input  wire logic low_oe,
   output var  logic mid_pin,
   output var  logic low_pin
);
   // ==========================================================
   // pin resolution
   // an undriven pin settles to its strap resistor level
   always_comb begin
      mid_pin = mid_oe ? mid_out : strap_mid_hi;
      low_pin = low_oe ? low_out : strap_low_hi;
   end
endmodule
`default_nettype wire

// file: bench/pin_strap_status_control_bench.sv
// Purpose: random and corner tests of strap capture and status pins
// Assumes: pssc_top with 29 data bits, core_clk at 100 MHz
// Notes:   fixed seed, so every run repeats
`timescale 1ns/1ns
`default_nettype none
module pin_strap_status_control_bench;
   import pssc_pkg::*;
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
   logic core_clk, rst_n, power_down_n, output_enable_n, mid_hi, low_hi;
   logic control_protocol_select, address_strap_mid_in, address_strap_low_in;
   logic aux_ctl_three_src, aux_ctl_zero_src, pixel_clock_src, link_error;
   logic pll_locked, word_aligned, audio_clock_source_sel, audio_ws_src;
   logic audio_sck_src, aux_control_out_three, aux_control_out_three_oe;
   logic aux_control_out_zero, aux_control_out_zero_oe, pixel_clock_out;
   logic pixel_out_oe, strap_valid, ctl_proto_i2c, powered_down, error_out_n;
   logic lock_out, audio_ws_out, audio_ws_oe, audio_sck_out, audio_sck_oe;
   logic [1:0]  bus_width_select, address_strap_q;
   logic [28:0] pixel_data_src, pixel_data_out;
   logic [31:0] seed = 32'hACCE;
   logic        first_proto;
   int          n_errors = 0;
   int          num_checks = 0;
   pssc_top #(.DW(29)) uut (.core_clk, .rst_n, .power_down_n, .output_enable_n,
      .bus_width_select, .control_protocol_select, .address_strap_mid_in,
      .address_strap_low_in, .aux_ctl_three_src, .aux_ctl_zero_src,
      .pixel_clock_src, .pixel_data_src, .link_error, .pll_locked,
      .word_aligned, .audio_clock_source_sel, .audio_ws_src, .audio_sck_src,
      .aux_control_out_three, .aux_control_out_three_oe, .aux_control_out_zero,
      .aux_control_out_zero_oe, .pixel_clock_out, .pixel_data_out,
      .pixel_out_oe, .address_strap_q, .strap_valid, .ctl_proto_i2c,
      .powered_down, .error_out_n, .lock_out, .audio_ws_out, .audio_ws_oe,
      .audio_sck_out, .audio_sck_oe);
   pssc_board_model board (.strap_mid_hi(mid_hi), .strap_low_hi(low_hi),
      .mid_out(aux_control_out_three), .mid_oe(aux_control_out_three_oe),
      .low_out(aux_control_out_zero), .low_oe(aux_control_out_zero_oe),
      .mid_pin(address_strap_mid_in), .low_pin(address_strap_low_in));
   // ==========================================================
   // helpers
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   function automatic logic exp_aux(input logic [1:0] w, input logic s);
      return (w == 2'h2) ? s : 1'h0;
   endfunction
   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic wait_for(ref logic s, input logic v);
      for (int i = 0; i < 60 && s !== v; i++) tick(1);
      if (s !== v) begin
         n_errors++;
         $display("wait ran out at t=%0t", $time);
         test_done();
      end
   endtask
   task automatic drive_src();
      logic [31:0] r;
      r = xs();
      {aux_ctl_three_src, aux_ctl_zero_src, pixel_clock_src, link_error,
         pll_locked, word_aligned, audio_ws_src, audio_sck_src} = r[7:0];
      r = xs();
      pixel_data_src = r[28:0];
   endtask
   // ==========================================================
   // one power-down and wake cycle with random straps, bus width stepped by k
   task automatic wake(input int k);
      logic [31:0] r;
      logic [1:0]  held;
      logic        e3;
      logic        e0;
      r = xs();
      power_down_n = 1'h0;
      wait_for(powered_down, 1'h1);
      drive_src();
      link_error = 1'h1;
      pll_locked = 1'h0;
      tick(2);
      `CHK(error_out_n, 1'h1)
      `CHK(lock_out, 1'h1)
      `CHK({aux_control_out_three_oe, aux_control_out_zero_oe}, 2'h0)
      {mid_hi, low_hi, output_enable_n} = r[2:0];
      if (k % 12 != 0) control_protocol_select = r[3];
      bus_width_select = 2'(k % 3);
      tick(6);
      power_down_n = 1'h1;
      wait_for(strap_valid, 1'h1);
      `CHK(powered_down, 1'h0)
      `CHK(address_strap_q, {mid_hi, low_hi})
      `CHK(ctl_proto_i2c, first_proto)
      drive_src();
      e3 = exp_aux(bus_width_select, aux_ctl_three_src);
      e0 = exp_aux(bus_width_select, aux_ctl_zero_src);
      tick(2);
      `CHK(aux_control_out_three_oe, ~output_enable_n)
      `CHK(aux_control_out_zero_oe, ~output_enable_n)
      `CHK(pixel_out_oe, ~output_enable_n)
      `CHK(aux_control_out_three, e3)
      `CHK(aux_control_out_zero, e0)
      `CHK(pixel_clock_out, pixel_clock_src)
      `CHK(pixel_data_out, pixel_data_src)
      `CHK(error_out_n, ~link_error)
      `CHK(lock_out, pll_locked & word_aligned)
      held = {mid_hi, low_hi};
      {mid_hi, low_hi} = ~held;
      tick(6);
      `CHK(address_strap_q, held)
      $display("wake %0d done", k);
   endtask
   initial begin
      core_clk = 1'h0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      {rst_n, power_down_n, mid_hi, low_hi} = '0;
      {aux_ctl_three_src, aux_ctl_zero_src, pixel_clock_src, link_error,
         pll_locked, word_aligned, audio_ws_src, audio_sck_src,
         audio_clock_source_sel} = '0;
      pixel_data_src = '0;
      output_enable_n = 1'h1;
      bus_width_select = 2'h2;
      first_proto = 1'(xs() >> 31);
      control_protocol_select = first_proto;
      tick(3);
      `CHK(strap_valid, 1'h0)
      `CHK({error_out_n, lock_out}, 2'h3)
      `CHK({audio_ws_oe, audio_sck_oe}, 2'h3)
      rst_n = 1'h1;
      $display("reset test done");
      for (int k = 0; k < 12; k++) wake(k);
      // mid-run reset: the other protocol strap is taken on the next wake
      rst_n = 1'h0;
      power_down_n = 1'h0;
      first_proto = ~first_proto;
      control_protocol_select = first_proto;
      tick(3);
      `CHK({powered_down, strap_valid, ctl_proto_i2c}, 3'h4)
      rst_n = 1'h1;
      wake(12);
      audio_clock_source_sel = 1'h1;
      tick(3);
      `CHK({audio_ws_oe, audio_sck_oe}, 2'h0)
      audio_clock_source_sel = 1'h0;
      drive_src();
      tick(3);
      `CHK({audio_ws_oe, audio_ws_out}, {1'h1, audio_ws_src})
      `CHK({audio_sck_oe, audio_sck_out}, {1'h1, audio_sck_src})
      $display("audio test done");
      test_done();
   end
endmodule
`default_nettype wire
